//--- rtl/scpm_defines.vh
// register offsets, field layouts and reset values of the split and power-management block
`ifndef SCPM_DEFINES_VH
`define SCPM_DEFINES_VH

// byte offsets in configuration space
`define SCPM_ADR_SPLIT_STAT     8'h84
`define SCPM_ADR_SPLIT          8'h8c
`define SCPM_ADR_PM_CAP         8'h90

// downstream split register fields
`define SCPM_CAP_LSB            0
`define SCPM_CAP_MSB            15
`define SCPM_LIMIT_LSB          16
`define SCPM_LIMIT_MSB          31
`define SCPM_SPLIT_CAP          16'h0010
`define SCPM_LIMIT_RST          16'h0010
`define SCPM_LIMIT_ALL          16'hffff
`define SCPM_LIMIT_UNBOUND      16'h0100

// split status register fields
`define SCPM_DELAYED_BIT        21
`define SCPM_OUTST_LSB          0
`define SCPM_OUTST_MSB          15

// power-management capability word fields
`define SCPM_PM_ID              8'h01
`define SCPM_PM_NEXT            8'ha8
`define SCPM_PM_VERSION         3'b011
`define SCPM_PM_CLOCK           1'b0
`define SCPM_PM_RSVD20          1'b0
`define SCPM_PM_DSI             1'b0
`define SCPM_PM_AUX             3'b001
`define SCPM_PM_D1              1'b0
`define SCPM_PM_D2              1'b0
`define SCPM_PM_WAKE_STATES     5'b11001

`endif

//--- rtl/scpm_sticky_flag.v
// sticky status flag, set by hardware, cleared by writing one
`timescale 1ns/1ns

module scpm_sticky_flag (
    input  wire clock,
    input  wire sys_rst,
    input  wire set_pulse,
    input  wire clear_pulse,
    output reg  flag
);

    // set beats a clear in the same cycle so no event is lost
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            flag <= 1'b0;
        end else if (set_pulse) begin
            flag <= 1'b1;
        end else if (clear_pulse) begin
            flag <= 1'b0;
        end
    end

endmodule

//--- rtl/scpm_commit_track.v
// running total of committed split completion space and the fit check
`timescale 1ns/1ns
`include "scpm_defines.vh"

module scpm_commit_track #(
    parameter W = 16
) (
    input  wire         clock,
    input  wire         sys_rst,
    input  wire [W-1:0] limit,
    input  wire [W-1:0] req_size,
    input  wire         commit,
    input  wire         release_valid,
    input  wire [W-1:0] release_size,
    output reg  [W-1:0] outstanding,
    output wire         unbounded,
    output wire         fits
);

    wire [W:0] sum_add;
    wire [W:0] sum_net;
    wire [W:0] after_add;

    // limits at or above the unbounded mark ignore free space; ffff is one of them
    assign unbounded = (limit >= `SCPM_LIMIT_UNBOUND);
    assign sum_add   = {1'b0, outstanding} + {1'b0, req_size};
    assign fits      = unbounded || (sum_add <= {1'b0, limit});

    // release first, then add; saturate so unbounded mode cannot wrap
    assign sum_net   = (release_valid && (release_size < outstanding)) ?
                       {1'b0, outstanding - release_size} :
                       (release_valid ? {(W+1){1'b0}} : {1'b0, outstanding});
    assign after_add = sum_net + {1'b0, req_size};

    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            outstanding <= {W{1'b0}};
        end else if (commit) begin
            outstanding <= after_add[W] ? {W{1'b1}} : after_add[W-1:0];
        end else begin
            outstanding <= sum_net[W-1:0];
        end
    end

endmodule

//--- rtl/scpm_regs.v
// split commitment and power-management capability registers on a wishbone slave
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "scpm_defines.vh"

module scpm_regs #(
    parameter SIZE_W = 16
) (
    input  wire              clock,
    input  wire              sys_rst,
    // wishbone classic slave
    input  wire              wb_cyc_i,
    input  wire              wb_stb_i,
    input  wire              wb_we_i,
    input  wire [7:0]        wb_adr_i,
    input  wire [3:0]        wb_sel_i,
    input  wire [31:0]       wb_dat_i,
    output reg  [31:0]       wb_dat_o,
    output reg               wb_ack_o,
    // split request from the forwarding datapath
    input  wire              req_valid,
    input  wire [SIZE_W-1:0] req_size,
    output reg               req_forward,
    output reg               req_held,
    // completion space handed back by the datapath
    input  wire              cpl_release,
    input  wire [SIZE_W-1:0] cpl_size,
    // state visible to the datapath
    output reg  [15:0]       commit_limit,
    output reg               split_delayed
);

    // request sequencer states
    localparam ST_IDLE  = 2'b00;
    localparam ST_CHECK = 2'b01;
    localparam ST_HOLD  = 2'b10;
    localparam ST_DONE  = 2'b11;

    // byte offsets of the mapped registers; the word index drops the byte lanes
    localparam [7:0] ADR_STAT  = `SCPM_ADR_SPLIT_STAT;
    localparam [7:0] ADR_SPLIT = `SCPM_ADR_SPLIT;
    localparam [7:0] ADR_PM    = `SCPM_ADR_PM_CAP;
    localparam [5:0] IDX_STAT  = ADR_STAT[7:2];
    localparam [5:0] IDX_SPLIT = ADR_SPLIT[7:2];
    localparam [5:0] IDX_PM    = ADR_PM[7:2];

    reg  [1:0]        state;
    reg  [1:0]        next_state;
    reg  [SIZE_W-1:0] held_size;
    reg  [SIZE_W-1:0] next_held_size;
    reg               next_forward;
    reg               next_held;
    reg               delay_event;
    reg  [31:0]       next_rdata;
    reg  [15:0]       next_limit;

    wire              bus_req;
    wire              bus_wr;
    wire              bus_rd;
    wire [5:0]        word_idx;
    wire              hit_stat;
    wire              hit_split;
    wire              hit_pm;
    wire              clear_delayed;
    wire              delayed_flag;
    wire [SIZE_W-1:0] outstanding;
    wire              unbounded;
    wire              fits;
    wire              commit_now;
    wire [31:0]       split_word;
    wire [31:0]       pm_word;
    wire [31:0]       stat_word;

    // -------- bus decode --------

    // a request is served once; ack low means it is not yet answered
    assign bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_wr    = bus_req && wb_we_i;
    assign bus_rd    = bus_req && !wb_we_i;
    assign word_idx  = wb_adr_i[7:2];
    assign hit_stat  = (word_idx == IDX_STAT);
    assign hit_split = (word_idx == IDX_SPLIT);
    assign hit_pm    = (word_idx == IDX_PM);

    // ack one cycle after the strobe, dropped the cycle after
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    // -------- register contents --------

    // capability half is a constant, limit half is the live register
    assign split_word = {commit_limit, `SCPM_SPLIT_CAP};

    // whole power-management header is wired from constants
    assign pm_word = {`SCPM_PM_WAKE_STATES,
                      `SCPM_PM_D2,
                      `SCPM_PM_D1,
                      `SCPM_PM_AUX,
                      `SCPM_PM_DSI,
                      `SCPM_PM_RSVD20,
                      `SCPM_PM_CLOCK,
                      `SCPM_PM_VERSION,
                      `SCPM_PM_NEXT,
                      `SCPM_PM_ID};

    // status word shows the sticky flag and the committed total
    assign stat_word = {10'h000, delayed_flag, 5'h00, outstanding[15:0]};

    // limit bytes follow the byte enables; the capability lanes are dropped
    always @* begin
        next_limit = commit_limit;
        if (bus_wr && hit_split) begin
            if (wb_sel_i[2]) begin
                next_limit[7:0] = wb_dat_i[23:16];
            end
            if (wb_sel_i[3]) begin
                next_limit[15:8] = wb_dat_i[31:24];
            end
        end
    end

    // writes to the header or capability half store nothing
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            commit_limit <= `SCPM_LIMIT_RST;
        end else begin
            commit_limit <= next_limit;
        end
    end

    // read mux, unmapped words answer zero
    always @* begin
        next_rdata = 32'h0000_0000;
        if (bus_rd) begin
            if (hit_split) begin
                next_rdata = split_word;
            end else if (hit_pm) begin
                next_rdata = pm_word;
            end else if (hit_stat) begin
                next_rdata = stat_word;
            end
        end
    end

    // read data registered alongside ack; held otherwise
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_rd) begin
            wb_dat_o <= next_rdata;
        end
    end

    // -------- delayed flag --------

    // writing one to bit 21 of the status word clears it
    assign clear_delayed = bus_wr && hit_stat && wb_sel_i[2] &&
                           wb_dat_i[`SCPM_DELAYED_BIT];

    scpm_sticky_flag u_delayed (
        .clock       (clock),
        .sys_rst     (sys_rst),
        .set_pulse   (delay_event),
        .clear_pulse (clear_delayed),
        .flag        (delayed_flag)
    );

    // registered copy for the datapath, one cycle behind the flag
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            split_delayed <= 1'b0;
        end else begin
            split_delayed <= delayed_flag;
        end
    end

    // -------- commitment tracking --------

    assign commit_now = next_forward;

    scpm_commit_track #(
        .W (SIZE_W)
    ) u_track (
        .clock         (clock),
        .sys_rst       (sys_rst),
        .limit         (commit_limit),
        .req_size      (held_size),
        .commit        (commit_now),
        .release_valid (cpl_release),
        .release_size  (cpl_size),
        .outstanding   (outstanding),
        .unbounded     (unbounded),
        .fits          (fits)
    );

    // -------- request sequencer --------

    // size is latched on entry so a changing input cannot skew the check
    always @* begin
        next_state     = state;
        next_held_size = held_size;
        next_forward   = 1'b0;
        next_held      = 1'b0;
        delay_event    = 1'b0;
        case (state)
            ST_IDLE: begin
                if (req_valid) begin
                    next_held_size = req_size;
                    next_state     = ST_CHECK;
                end
            end
            ST_CHECK: begin
                if (fits) begin
                    // unbounded limits always fit
                    next_forward = 1'b1;
                    next_state   = ST_DONE;
                end else begin
                    // flag raised once per held request
                    delay_event = 1'b1;
                    next_held   = 1'b1;
                    next_state  = ST_HOLD;
                end
            end
            ST_HOLD: begin
                // re-check each cycle; freed space or a new limit lets it go
                if (fits) begin
                    next_forward = 1'b1;
                    next_state   = ST_DONE;
                end else begin
                    next_held = 1'b1;
                end
            end
            ST_DONE: begin
                // wait for the datapath to drop its request
                if (!req_valid) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // sequencer registers and the forward and held outputs
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state       <= ST_IDLE;
            held_size   <= {SIZE_W{1'b0}};
            req_forward <= 1'b0;
            req_held    <= 1'b0;
        end else begin
            state       <= next_state;
            held_size   <= next_held_size;
            req_forward <= next_forward;
            req_held    <= next_held;
        end
    end

endmodule

//--- testbench/scpm_regs_props.sv
// concurrent checks on the ports of the split and power-management register block
`timescale 1ns/1ns

module scpm_regs_props #(
    parameter SIZE_W = 16
) (
    input wire              clock,
    input wire              sys_rst,
    input wire              wb_cyc_i,
    input wire              wb_stb_i,
    input wire              wb_we_i,
    input wire [7:0]        wb_adr_i,
    input wire [3:0]        wb_sel_i,
    input wire [31:0]       wb_dat_i,
    input wire [31:0]       wb_dat_o,
    input wire              wb_ack_o,
    input wire              req_valid,
    input wire [SIZE_W-1:0] req_size,
    input wire              req_forward,
    input wire              req_held,
    input wire              cpl_release,
    input wire [SIZE_W-1:0] cpl_size,
    input wire [15:0]       commit_limit,
    input wire              split_delayed
);
    // a bus request is taken only while no ack is out
    wire take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire at_split = wb_adr_i[7:2] == 6'h23;

    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    ack_timing_a: assert property (take |=> wb_ack_o)
        else $error("bus request not acked next cycle");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    pm_word_a: assert property (take && !wb_we_i && wb_adr_i[7:2] == 6'h24
        |=> wb_dat_o == 32'hc843a801) else $error("capability word wrong");
    split_read_a: assert property (take && !wb_we_i && at_split
        |=> wb_dat_o == {commit_limit, 16'h0010}) else $error("split word wrong");
    limit_write_a: assert property (take && wb_we_i && at_split && wb_sel_i[3:2] == 2'b11
        |=> commit_limit == $past(wb_dat_i[31:16])) else $error("limit not written");
    limit_keep_a: assert property (!(take && wb_we_i && at_split)
        |=> $stable(commit_limit)) else $error("limit changed without write");
    unbound_fwd_a: assert property ($rose(req_valid) && commit_limit >= 16'h0100
        |-> ##2 req_forward) else $error("unbounded limit did not forward");
    held_flag_a: assert property ($rose(req_held) |=> split_delayed)
        else $error("held request left flag clear");
    held_keep_a: assert property (req_held |=> req_held || req_forward)
        else $error("held request dropped without forward");
endmodule

bind scpm_regs scpm_regs_props #(.SIZE_W(SIZE_W)) props (.clock(clock), .sys_rst(sys_rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .req_valid(req_valid), .req_size(req_size), .req_forward(req_forward),
    .req_held(req_held), .cpl_release(cpl_release), .cpl_size(cpl_size),
    .commit_limit(commit_limit), .split_delayed(split_delayed));

//--- testbench/scpm_regs_tb.sv
// self-checking bench for the split and power-management register block
`timescale 1ns/1ns
`define CHK(g, e, m) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
    $display("[ERR] %0t %s got %h exp %h", $time, m, g, e); end end

module scpm_regs_tb;
    reg         clock = 0, sys_rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    reg  [7:0]  wb_adr_i = 0;
    reg  [3:0]  wb_sel_i = 0;
    reg  [31:0] wb_dat_i = 0, rd, d;
    reg         req_valid = 0, cpl_release = 0, got;
    reg  [15:0] req_size = 0, cpl_size = 0, s1, s2;
    wire [31:0] wb_dat_o;
    wire [15:0] commit_limit;
    wire        wb_ack_o, req_forward, req_held, split_delayed;
    integer     mismatches = 0, cmp_count = 0, cycles = 0, i;

    scpm_regs dut (.clock(clock), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .req_valid(req_valid), .req_size(req_size), .req_forward(req_forward),
        .req_held(req_held), .cpl_release(cpl_release), .cpl_size(cpl_size),
        .commit_limit(commit_limit), .split_delayed(split_delayed));

    always #4 clock = ~clock;

    // expected words built field by field
    function [31:0] pm_word();
        pm_word = {5'b11001, 1'b0, 1'b0, 3'b001, 1'b0, 1'b0, 1'b0, 3'b011, 8'ha8, 8'h01};
    endfunction
    function [31:0] split_word(input [15:0] lim);
        split_word = {lim, 16'h0010};
    endfunction
    function [31:0] stat_word(input flag, input [15:0] outst);
        stat_word = {10'b0, flag, 5'b0, outst};
    endfunction

    task give_verdict;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
            if (mismatches == 0 && cmp_count > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask

    // hang guard, far beyond the fewer than two hundred cycles the tests need
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            give_verdict;
        end
    end

    // one classic cycle; ack and data are taken at the same edge
    task wb(input we, input [7:0] a, input [3:0] s, input [31:0] dat);
        integer k;
        begin
            @(posedge clock);
            wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= we;
            wb_adr_i <= a; wb_sel_i <= s; wb_dat_i <= dat;
            for (k = 0; k < 20; k++) begin
                @(posedge clock);
                if (wb_ack_o === 1'b1) break;
            end
            rd = wb_dat_o;
            wb_cyc_i <= 0; wb_stb_i <= 0;
        end
    endtask

    // request stays up until forwarded; spacing keeps the sequencer idle before the next
    task req(input [15:0] sz);
        integer k;
        begin
            @(posedge clock);
            req_valid <= 1; req_size <= sz;
            fwd_wait();
        end
    endtask
    task fwd_wait;
        integer k;
        begin
            got = 0;
            for (k = 0; k < 6 && !got; k++) begin
                @(posedge clock);
                got = req_forward;
            end
            if (got) begin
                req_valid <= 0;
                repeat (3) @(posedge clock);
            end
        end
    endtask
    task release_space(input [15:0] sz);
        begin
            @(posedge clock);
            cpl_release <= 1; cpl_size <= sz;
            @(posedge clock);
            cpl_release <= 0;
        end
    endtask
    task tend(input string n);
        $display("test %0s done", n);
    endtask

    initial begin
        void'($urandom(32'h5b0b25a1));
        repeat (8) @(posedge clock);
        sys_rst <= 0;
        wb(0, 8'h8c, 4'hf, 0); `CHK(rd, split_word(16'h0010), "split reset")
        wb(0, 8'h90, 4'hf, 0); `CHK(rd, pm_word(), "pm word")
        wb(0, 8'h84, 4'hf, 0); `CHK(rd, stat_word(0, 0), "status reset")
        tend("reset");
        // read-only places keep their value, unmapped reads zero
        wb(1, 8'h90, 4'hf, $urandom); wb(0, 8'h90, 4'hf, 0);
        `CHK(rd, pm_word(), "pm after write")
        wb(1, 8'h8c, 4'h3, $urandom); wb(0, 8'h8c, 4'hf, 0);
        `CHK(rd, split_word(16'h0010), "cap after write")
        wb(1, 8'h40, 4'hf, $urandom); wb(0, 8'h40, 4'hf, 0);
        `CHK(rd, 32'h0, "unmapped")
        tend("read_only");
        for (i = 0; i < 4; i++) begin
            d = (i == 0) ? 32'hffff0000 : $urandom;
            wb(1, 8'h8c, 4'hf, d); wb(0, 8'h8c, 4'hf, 0);
            `CHK(rd, split_word(d[31:16]), "limit readback")
            `CHK(commit_limit, d[31:16], "limit port")
        end
        tend("limit");
        // tight limit: second request overflows and waits for released space
        wb(1, 8'h8c, 4'hf, 32'h00040000);
        s1 = 1 + $urandom % 4;
        s2 = 5 - s1;
        req(s1); `CHK(got, 1'b1, "fit forward")
        req(s2); `CHK(got, 1'b0, "overflow forward")
        `CHK(req_held, 1'b1, "held")
        wb(0, 8'h84, 4'hf, 0); `CHK(rd, stat_word(1, s1), "delayed set")
        `CHK(split_delayed, 1'b1, "delayed port set")
        release_space(s1);
        fwd_wait(); `CHK(got, 1'b1, "forward after release")
        wb(1, 8'h84, 4'h4, 32'h00200000); wb(0, 8'h84, 4'hf, 0);
        `CHK(rd, stat_word(0, s2), "delayed cleared")
        `CHK(split_delayed, 1'b0, "delayed port cleared")
        tend("hold");
        // one below the unbounded threshold still counts, at and above it does not
        wb(1, 8'h8c, 4'hf, 32'h00ff0000);
        req(16'h0100 - s2); `CHK(got, 1'b0, "limit 00ff held")
        release_space(s2);
        fwd_wait(); `CHK(got, 1'b1, "limit 00ff released")
        wb(1, 8'h8c, 4'hf, 32'h01000000);
        req(16'hffff); `CHK(got, 1'b1, "limit 0100")
        req($urandom); `CHK(got, 1'b1, "limit 0100 random")
        wb(1, 8'h8c, 4'hf, 32'hffff0000);
        req(16'hffff); `CHK(got, 1'b1, "limit ffff")
        tend("unbounded");
        give_verdict;
    end
endmodule
